// ===== src/lp_state_pkg.sv
// Package for the low-power state control block: states, carriers, constants.
package lp_state_pkg;

  // ==========================================================================
  // Power states (Gray coded along normal -> stop-grant -> sleep -> deep sleep)
  typedef enum logic [2:0] {
    ST_NORMAL     = 3'h0,
    ST_STOP_GRANT = 3'h1,
    ST_SLEEP      = 3'h3,
    ST_DEEP_SLEEP = 3'h2,
    ST_MGMT       = 3'h6
  } power_state_t;

  // ==========================================================================
  // Bus acknowledge transaction codes
  typedef enum logic [1:0] {
    ACK_NONE       = 2'h0,
    ACK_STOP_GRANT = 2'h1,
    ACK_MGMT       = 2'h2
  } ack_kind_t;

  // Synchronised sideband levels, active high after inversion
  typedef struct packed {
    logic clock_stop;
    logic sleep;
    logic deep_sleep;
    logic mgmt_irq;
  } sideband_t;

  // Internal clock gating enables, one per unit group
  typedef struct packed {
    logic core;       // Core execution units
    logic bus_unit;   // Front-side bus unit
    logic irq_unit;   // Local interrupt unit
    logic pll;        // PLL, stops only in deep sleep
  } clk_gate_t;

  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned SIDEBAND_W    = 4;
  // Bus clock is judged stopped after this many cycles without an edge
  localparam int unsigned BCLK_IDLE_MAX = 8;
  localparam logic [3:0]  BCLK_IDLE_CNT_W1 = 4'h1;
  localparam logic [3:0]  BCLK_IDLE_LIMIT  = 4'h8;
  localparam logic [3:0]  BCLK_IDLE_ZERO   = 4'h0;
  localparam clk_gate_t   GATE_ALL_ON   = 4'hF;
  localparam clk_gate_t   GATE_STOP_GNT = 4'h7;
  localparam clk_gate_t   GATE_PLL_ONLY = 4'h1;
  localparam clk_gate_t   GATE_ALL_OFF  = 4'h0;

endpackage

// ===== src/low_power_state_control.sv
// Low-power state controller: stop-grant, sleep, deep sleep and management mode.
//
// Contract
// - An active clock-stop request moves normal execution into stop-grant.
// - Entering stop-grant issues a stop-grant acknowledge, then gates all but bus, irq and PLL units.
// - In stop-grant, snooping and interrupt servicing stay enabled.
// - Removing clock-stop restarts all internal clocks and resumes execution.
// - Clock-stop is asynchronous, synchronised inside, and never touches the bus clock.
// - Sleep request during stop-grant enters sleep, leaving only the PLL clocked.
// - In sleep, snoops and interrupt requests are ignored.
// - In sleep, only reset, sleep removal, deep-sleep assertion and a stopped bus clock are honoured.
// - Sleep removal in sleep returns to stop-grant and restarts bus and irq clocks.
// - In sleep, a stopped bus clock or a deep-sleep request enters deep sleep.
// - An accepted management interrupt saves state and enters management mode.
// - Management mode issues a management acknowledge and then starts the handler.
// - Management interrupt active at reset release raises outputs_tristate and holds ack_valid, snoop_enable, irq_enable and executing low.
// - The presence indicator is always driven low.
// - Reset returns any state to the initial state and invalidates caches without writeback.
`timescale 1ns/1ps
`default_nettype none

module low_power_state_control (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clock_stop_request_n,
  input  wire logic                       sleep_request_n,
  input  wire logic                       deep_sleep_request_n,
  input  wire logic                       mgmt_interrupt_n,
  input  wire logic                       bus_clk_edge,
  input  wire logic                       mgmt_handler_done,
  output var  lp_state_pkg::power_state_t power_state,
  output var  lp_state_pkg::clk_gate_t    clk_gate,
  output var  lp_state_pkg::ack_kind_t    ack_kind,
  output var  logic                       ack_valid,
  output var  logic                       snoop_enable,
  output var  logic                       irq_enable,
  output var  logic                       executing,
  output var  logic                       state_save,
  output var  logic                       cache_invalidate,
  output var  logic                       system_mgmt_mode,
  output var  logic                       outputs_tristate,
  output var  logic                       presence_indicator_n
);
  import lp_state_pkg::*;

  // ==========================================================================
  // Sideband synchronisers
  logic [SIDEBAND_W-1:0] raw_w;
  logic [SIDEBAND_W-1:0] sync1_q;
  logic [SIDEBAND_W-1:0] sync2_q;
  sideband_t             sb_w;

  assign raw_w = {~clock_stop_request_n, ~sleep_request_n,
                  ~deep_sleep_request_n, ~mgmt_interrupt_n};

  // Two flops per line; only the second stage is read by the logic
  genvar g;
  generate
    for (g = 0; g < SIDEBAND_W; g++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= raw_w[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  assign sb_w = sideband_t'(sync2_q);

  // ==========================================================================
  // Bus clock watchdog: no bus clock edge for a while counts as stopped
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  logic       bclk_stopped_w;

  assign bclk_stopped_w = (idle_q == BCLK_IDLE_LIMIT);
  assign idle_d = bus_clk_edge   ? BCLK_IDLE_ZERO :
                  bclk_stopped_w ? idle_q : idle_q + BCLK_IDLE_CNT_W1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= BCLK_IDLE_ZERO;
    end else begin
      idle_q <= idle_d;
    end
  end

  // ==========================================================================
  // Reset-release strap: catch the management interrupt on the first edge
  logic first_q;
  logic tri_q;

  // Sampled raw, since synchronisers are still at reset value on that edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      tri_q   <= 1'b0;
    end else begin
      first_q <= 1'b0;
      if (first_q) begin
        tri_q <= ~mgmt_interrupt_n;
      end
    end
  end

  // ==========================================================================
  // State machine
  power_state_t state_q;
  power_state_t state_d;
  logic         ack_pend_q;
  logic         ack_pend_d;

  // Management interrupts are accepted only while execution could run
  logic mgmt_take_w;
  assign mgmt_take_w = sb_w.mgmt_irq && (state_q == ST_NORMAL);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (mgmt_take_w) begin
          state_d = ST_MGMT;
        end else if (sb_w.clock_stop) begin
          state_d = ST_STOP_GRANT;
        end
      end
      ST_STOP_GRANT: begin
        if (sb_w.sleep) begin
          state_d = ST_SLEEP;
        end else if (!sb_w.clock_stop) begin
          state_d = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        // Only these events are looked at here
        if (sb_w.deep_sleep || bclk_stopped_w) begin
          state_d = ST_DEEP_SLEEP;
        end else if (!sb_w.sleep) begin
          state_d = ST_STOP_GRANT;
        end
      end
      ST_DEEP_SLEEP: begin
        // Leaves once both deep-sleep causes are gone
        if (!sb_w.deep_sleep && !bclk_stopped_w) begin
          state_d = ST_SLEEP;
        end
      end
      ST_MGMT: begin
        if (mgmt_handler_done) begin
          state_d = ST_NORMAL;
        end
      end
      default: state_d = ST_NORMAL;
    endcase
  end

  // Acknowledge is owed on entry from normal execution into stop-grant or management mode
  logic enter_sg_w;
  logic enter_mg_w;
  assign enter_sg_w = (state_d == ST_STOP_GRANT) && (state_q == ST_NORMAL);
  assign enter_mg_w = (state_d == ST_MGMT) && (state_q != ST_MGMT);
  assign ack_pend_d = enter_sg_w || enter_mg_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_NORMAL;
      ack_pend_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      ack_pend_q <= ack_pend_d;
    end
  end

  // ==========================================================================
  // Output decode
  clk_gate_t gate_w;
  logic      snoop_w;
  logic      exec_w;

  // Core gating lags the acknowledge by one cycle so the ack can go out first
  assign gate_w =
    (state_q == ST_STOP_GRANT && !ack_pend_q) ? GATE_STOP_GNT :
    (state_q == ST_STOP_GRANT)                ? GATE_ALL_ON   :
    (state_q == ST_SLEEP)                     ? GATE_PLL_ONLY :
    (state_q == ST_DEEP_SLEEP)                ? GATE_ALL_OFF  : GATE_ALL_ON;
  assign snoop_w = (state_q != ST_SLEEP) && (state_q != ST_DEEP_SLEEP);
  assign exec_w  = (state_q == ST_NORMAL) ||
                   (state_q == ST_MGMT && !ack_pend_q);

  // All outputs registered; bus clock itself is never gated here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state          <= ST_NORMAL;
      clk_gate             <= GATE_ALL_ON;
      ack_kind             <= ACK_NONE;
      ack_valid            <= 1'b0;
      snoop_enable         <= 1'b0;
      irq_enable           <= 1'b0;
      executing            <= 1'b0;
      state_save           <= 1'b0;
      cache_invalidate     <= 1'b1;
      system_mgmt_mode     <= 1'b0;
      outputs_tristate     <= 1'b0;
      presence_indicator_n <= 1'b0;
    end else begin
      power_state          <= state_q;
      clk_gate             <= gate_w;
      ack_valid            <= ack_pend_q && !tri_q;
      ack_kind             <= !ack_pend_q ? ACK_NONE :
                              (state_q == ST_MGMT) ? ACK_MGMT : ACK_STOP_GRANT;
      snoop_enable         <= snoop_w && !tri_q;
      irq_enable           <= snoop_w && !tri_q;
      executing            <= exec_w && !tri_q;
      state_save           <= ack_pend_q && (state_q == ST_MGMT);
      cache_invalidate     <= 1'b0;
      system_mgmt_mode     <= (state_q == ST_MGMT);
      outputs_tristate     <= tri_q;
      presence_indicator_n <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  // Stop-grant entry, its acknowledge, then the gating and the services kept alive
  stopgnt_entry_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_NORMAL && sb_w.clock_stop && !sb_w.mgmt_irq)
      |=> state_q == ST_STOP_GRANT)
    else $error("stop-grant not entered");
  stopgnt_ack_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_NORMAL && state_d == ST_STOP_GRANT && !tri_q)
      |=> ##1 (ack_valid && ack_kind == ACK_STOP_GRANT))
    else $error("no stop-grant ack");
  stopgnt_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP_GRANT && !ack_pend_q)
      |=> clk_gate == GATE_STOP_GNT)
    else $error("stop-grant gating wrong");
  stopgnt_service_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP_GRANT && !tri_q)
      |=> snoop_enable && irq_enable)
    else $error("snoop or irq lost in stop-grant");

  // Leaving stop-grant, and normal running with every clock on
  resume_exec_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP_GRANT && !sb_w.clock_stop && !sb_w.sleep)
      |=> ##1 (clk_gate == GATE_ALL_ON && (executing || tri_q)))
    else $error("no resume");
  normal_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_NORMAL)
      |=> clk_gate == GATE_ALL_ON && (executing || tri_q))
    else $error("normal running gated");
  // Sleep is never entered directly from normal or management mode
  sleep_guard_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_NORMAL || state_q == ST_MGMT)
      |=> state_q != ST_SLEEP)
    else $error("sleep taken outside stop-grant");

  // Synchroniser depth; the first edges after release still see reset contents
  sync_delay_a : assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 2)
      |-> sync2_q == $past(raw_w, 2))
    else $error("sync depth wrong");

  // Sleep and deep sleep
  sleep_entry_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP_GRANT && sb_w.sleep) |=> state_q == ST_SLEEP ##1
      (clk_gate == GATE_PLL_ONLY || state_q != ST_SLEEP))
    else $error("sleep entry wrong");
  sleep_quiet_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP)
      |=> !snoop_enable && !irq_enable)
    else $error("snoop in sleep");
  sleep_exit_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && !sb_w.sleep && !sb_w.deep_sleep && !bclk_stopped_w)
      |=> state_q == ST_STOP_GRANT)
    else $error("sleep exit wrong");
  deep_entry_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && (sb_w.deep_sleep || bclk_stopped_w))
      |=> state_q == ST_DEEP_SLEEP)
    else $error("deep sleep missed");
  deep_gate_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_DEEP_SLEEP)
      |=> clk_gate == GATE_ALL_OFF)
    else $error("deep sleep gating wrong");

  // Management mode: entry, acknowledge, and the handler only after the acknowledge
  mgmt_entry_a : assert property (@(posedge clk) disable iff (!rst_n)
    mgmt_take_w
      |=> state_q == ST_MGMT ##1 (state_save && system_mgmt_mode))
    else $error("mgmt entry wrong");
  mgmt_ack_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_MGMT && ack_pend_q && !tri_q)
      |=> ack_valid && ack_kind == ACK_MGMT && state_save)
    else $error("no mgmt ack");
  mgmt_order_a : assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_MGMT && ack_pend_q && !tri_q)
      |=> !executing ##1 executing)
    else $error("handler order wrong");

  // Reset, strap and presence
  cache_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
    cache_invalidate
      |=> !cache_invalidate)
    else $error("cache invalidate stuck");
  presence_low_a : assert property (@(posedge clk) disable iff (!rst_n)
    !presence_indicator_n)
    else $error("presence not low");
  tristate_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
    tri_q
      |=> outputs_tristate && !ack_valid)
    else $error("tristate lost");

endmodule

`default_nettype wire

// ===== verification/platform_sideband_model.sv
// Platform logic model: drives the sideband request levels and bus clock edges.
`timescale 1ns/1ps
`default_nettype none

module platform_sideband_model (
  input  wire logic                    clk,
  input  wire lp_state_pkg::sideband_t want,
  input  wire logic                    bus_run,
  output var  logic                    clock_stop_request_n,
  output var  logic                    sleep_request_n,
  output var  logic                    deep_sleep_request_n,
  output var  logic                    mgmt_interrupt_n,
  output var  logic                    bus_clk_edge
);
  import lp_state_pkg::*;

  // ==========================================================================
  // Sideband levels
  // Driven mid-cycle, away from the bench's edge, since platform logic is asynchronous
  always @(posedge clk) begin
    #3;
    clock_stop_request_n <= ~want.clock_stop;
    sleep_request_n      <= ~want.sleep;
    deep_sleep_request_n <= ~want.deep_sleep;
    mgmt_interrupt_n     <= ~want.mgmt_irq;
  end

  // Bus clock edges every other cycle; clock-stop never affects them
  initial begin
    bus_clk_edge = 1'b0;
    forever begin
      @(posedge clk);
      #3;
      bus_clk_edge <= bus_run & ~bus_clk_edge;
    end
  end

endmodule

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the low-power state controller.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import lp_state_pkg::*;

  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  sideband_t    want = '0;
  logic         bus_run = 1'b1;
  logic         done_pulse = 1'b0;
  logic         stop_n, sleep_n, deep_n, mgmt_n, bus_edge;
  power_state_t power_state;
  clk_gate_t    clk_gate;
  ack_kind_t    ack_kind;
  logic         ack_valid, snoop_enable, irq_enable, executing, state_save;
  logic         cache_invalidate, system_mgmt_mode, outputs_tristate, presence_n;
  int           num_errors = 0;
  int           n_compared = 0;
  int           seed = 32'hc41a4c7c;
  int           n;

  always #5 clk = ~clk;

  platform_sideband_model partner (.clk(clk), .want(want), .bus_run(bus_run),
    .clock_stop_request_n(stop_n), .sleep_request_n(sleep_n),
    .deep_sleep_request_n(deep_n), .mgmt_interrupt_n(mgmt_n), .bus_clk_edge(bus_edge));

  low_power_state_control dut (.clk(clk), .rst_n(rst_n), .clock_stop_request_n(stop_n),
    .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n), .mgmt_interrupt_n(mgmt_n),
    .bus_clk_edge(bus_edge), .mgmt_handler_done(done_pulse), .power_state(power_state),
    .clk_gate(clk_gate), .ack_kind(ack_kind), .ack_valid(ack_valid),
    .snoop_enable(snoop_enable), .irq_enable(irq_enable), .executing(executing),
    .state_save(state_save), .cache_invalidate(cache_invalidate),
    .system_mgmt_mode(system_mgmt_mode), .outputs_tristate(outputs_tristate),
    .presence_indicator_n(presence_n));

  // ==========================================================================
  // Helpers
  // Expected gating per steady state, read after the entry acknowledge has gone by
  function automatic clk_gate_t exp_gate(input power_state_t s);
    case (s)
      ST_STOP_GRANT: return GATE_STOP_GNT;
      ST_SLEEP:      return GATE_PLL_ONLY;
      ST_DEEP_SLEEP: return GATE_ALL_OFF;
      default:       return GATE_ALL_ON;
    endcase
  endfunction

  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a state; a timeout fails the compare and ends the run
  task automatic go(input power_state_t s);
    int i;
    for (i = 0; i < 40 && power_state !== s; i++) tick(1);
    chk(power_state, s);
    if (power_state !== s) conclude();
    tick(3);
    chk(clk_gate, exp_gate(s));
  endtask

  // The acknowledge pulse stands one cycle, so it is polled every cycle
  task automatic wait_ack(input ack_kind_t k);
    int i;
    for (i = 0; i < 12 && ack_valid !== 1'b1; i++) tick(1);
    chk(ack_valid, 1'b1);
    if (ack_valid !== 1'b1) conclude();
    chk(ack_kind, k);
    chk(state_save, k == ACK_MGMT);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    tick(1);
    chk({clk_gate, cache_invalidate, presence_n}, 6'h3E);
    tick(1);
    rst_n = 1'b1;
    want.sleep = 1'b1;
    tick(10);
    chk({power_state, executing}, 4'h1);
    want.sleep = 1'b0;
    tick(4);
    want.clock_stop = 1'b1;
    wait_ack(ACK_STOP_GRANT);
    go(ST_STOP_GRANT);
    chk({snoop_enable, irq_enable, executing}, 3'h6);
    want.sleep = 1'b1;
    go(ST_SLEEP);
    chk({snoop_enable, irq_enable}, 2'h0);
    want.clock_stop = 1'b0;
    want.mgmt_irq = 1'b1;
    tick(10);
    chk(power_state, ST_SLEEP);
    want = '{clock_stop: 1'b1, sleep: 1'b1, deep_sleep: 1'b1, mgmt_irq: 1'b0};
    go(ST_DEEP_SLEEP);
    want.deep_sleep = 1'b0;
    go(ST_SLEEP);
    bus_run = 1'b0;
    go(ST_DEEP_SLEEP);
    bus_run = 1'b1;
    go(ST_SLEEP);
    want.sleep = 1'b0;
    go(ST_STOP_GRANT);
    want.clock_stop = 1'b0;
    go(ST_NORMAL);
    chk(executing, 1'b1);
    want.mgmt_irq = 1'b1;
    wait_ack(ACK_MGMT);
    chk({power_state, system_mgmt_mode}, {ST_MGMT, 1'b1});
    tick(1);
    chk(executing, 1'b1);
    want.mgmt_irq = 1'b0;
    // Let the synchronised request drain first, or normal would take it again
    tick(4);
    done_pulse = 1'b1;
    tick(1);
    done_pulse = 1'b0;
    go(ST_NORMAL);
    // Random dwell times between stop-grant entries and exits
    repeat (6) begin
      n = 2 + ($unsigned($random(seed)) % 9);
      tick(n);
      want.clock_stop = 1'b1;
      wait_ack(ACK_STOP_GRANT);
      go(ST_STOP_GRANT);
      tick($unsigned($random(seed)) % 7);
      want.clock_stop = 1'b0;
      go(ST_NORMAL);
    end
    // Management interrupt held across reset release tristates the outputs
    rst_n = 1'b0;
    want.mgmt_irq = 1'b1;
    tick(3);
    chk(cache_invalidate, 1'b1);
    rst_n = 1'b1;
    tick(5);
    chk({outputs_tristate, snoop_enable, irq_enable, executing}, 4'h8);
    want.mgmt_irq = 1'b0;
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(5);
    chk({outputs_tristate, power_state, executing}, 5'h1);
    conclude();
  end

endmodule

`default_nettype wire
